//--- pkg/sih_regs.svh
// Purpose: Register offsets, field positions, reset values and divide counts
// Assumes: Byte offsets on the local register port, one 32-bit word each
// Notes:   Definitions only
`ifndef SIH_REGS_SVH
`define SIH_REGS_SVH

// ==========================================================
// Register offsets
`define SIH_OFF_BASE_CONTROL 8'h00
`define SIH_OFF_DESIGN_REVISION_ID 8'h04
`define SIH_OFF_CHANNEL_START_SET 8'h08
`define SIH_OFF_CHANNEL_START_CLEAR 8'h0C
`define SIH_OFF_PARALLEL_OUTPUT_DATA 8'h10
`define SIH_OFF_LINE_DIRECTION 8'h14
`define SIH_OFF_LINE_TERMINATION 8'h18
`define SIH_OFF_LINE_SOURCE_SELECT 8'h1C
`define SIH_OFF_UPPER_LINE_CONTROL 8'h20
`define SIH_OFF_SWITCH_STATUS 8'h24
`define SIH_OFF_PLL_COMMAND 8'h28
`define SIH_OFF_PLL_COMMAND_READBACK 8'h2C
`define SIH_OFF_LINE_READBACK 8'hC0
`define SIH_OFF_UPPER_LINE_READBACK 8'hC4
`define SIH_OFF_MESSAGE_TARGET_ADDRESS 8'hD4

// ==========================================================
// Field positions
`define SIH_BASE_IRQ_MASTER 0
`define SIH_BASE_IRQ_SET 1
`define SIH_BASE_MSG_ENABLE 2
`define SIH_BASE_MSG_CLEAR 3
`define SIH_BASE_REF_SELECT 4
`define SIH_BASE_WIDTH 5
`define SIH_UPPER_DATA_LSB 0
`define SIH_UPPER_DIR_LSB 8
`define SIH_UPPER_TERM_LSB 16
`define SIH_UPPER_MUX_LSB 24
`define SIH_SWITCH_LSB 16
`define SIH_PLL_DATA 0
`define SIH_PLL_SCLK 1
`define SIH_PLL_SPARE 2
`define SIH_PLL_ENABLE 3

// ==========================================================
// Reset values and divide counts
`define SIH_RESET_WORD 32'h0000_0000
`define SIH_DIV_HIGH 7'h08
`define SIH_DIV_LOW 7'h64

`endif

//--- pkg/sih_pkg.sv
// Purpose: Types shared by the register bank
// Assumes: Constants live in sih_regs.svh
// Notes:   Nothing here is imported; use sih_pkg::name
package sih_pkg;

  // ==========================================================
  // Types
  typedef logic [31:0] sih_word_t;
  typedef logic [33:0] sih_lines_t;

  // Message-interrupt write sequencer
  typedef enum logic [0:0] {
    SIH_MSG_IDLE,
    SIH_MSG_WAIT
  } sih_msg_e;

endpackage

//--- core/sih_sync.sv
// Purpose: Three-flop synchroniser with agreement gate for pin inputs
// Assumes: Inputs are asynchronous to CLOCK_IN
// Notes:   A bit changes once the second and third stages agree
`timescale 1ns/10ps
`default_nettype none

module sih_sync #(
  parameter int W = 1
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_d;
  logic [W-1:0] agree;

  // ==========================================================
  // Agreement gate, first stage is never looked at here
  always_comb begin
    agree = ~(s2_q ^ s3_q);
    out_d = (sync_out & ~agree) | (s3_q & agree);
  end

  // Chain and held output
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      sync_out <= '0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      sync_out <= out_d;
    end
  end

endmodule // sih_sync

`default_nettype wire

//--- core/sih_top.sv
// Purpose: Host register bank of a 32-channel serial card
// Assumes: Local register port behind the host bus core, 250 MHz clock
// Notes:   Reads answer one cycle after the strobe; writes act at the edge
// Overview of operation
// [RL1] Master enable passes interrupt requests to the carrier line, else polled only
// [RL2] Interrupt set with master enable forces a test interrupt request
// [RL3] Message enable sends interrupts as writes to the message target address
// [RL4] Message collect clear empties stored message events before enabling
// [RL5] Reference select picks PLL A or 40 MHz oscillator; divide by 8 and 100
// [RL6] Base control bits are active high and reset to zero
// [RL7] Identifier is read-only: design id high half, revision low half
// [RL8] Writing ones to start set starts channels; reading shows active ones
// [RL9] A channel state machine may clear its own start bit
// [RL10] Writing ones to start clear stops those channels after current work
// [RL11] Channels sense a start clear within 12 channel clock periods
// [RL12] Output data drives a line only when output and parallel selected
// [RL13] Reading output data returns the stored value, not the pins
// [RL14] Direction one transmits, zero receives, only under parallel control
// [RL15] Termination one closes the switch, independent of mux
// [RL16] Mux one hands the line to state machine, zero to parallel port
// [RL17] Upper control holds data, direction, termination, mux of lines 33-32
// [RL18] Upper mux set forces that line's data to zero
// [RL19] Line readback returns sampled levels of lines 31-0
// [RL20] Upper readback returns lines 33-32 in its two low bits
// [RL21] Switch status shows eight DIP switches in bits 23-16
// [RL22] PLL data line driven low only when enabled and written low
// [RL23] Writing zero to start set or clear leaves channels unchanged
`timescale 1ns/10ps
`default_nettype none
`include "sih_regs.svh"

module sih_top #(
  parameter logic [15:0] DESIGN_ID = 16'h5A5A, // Arbitrary value
  parameter logic [15:0] FW_REVISION = 16'h0100 // Arbitrary value
) (
  // Clock and reset
  input wire logic CLOCK_IN,
  input wire logic RESET_IN,
  // Local register port
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  input wire logic [31:0] REG_WDATA_IN,
  output logic [31:0] REG_RDATA_OUT,
  output logic REG_RVALID_OUT,
  // Interrupts
  input wire logic [31:0] CHAN_IRQ_IN,
  output logic CARRIER_IRQ_OUT,
  output logic MSG_WR_REQ_OUT,
  output logic [31:0] MSG_WR_ADDR_OUT,
  input wire logic MSG_WR_ACK_IN,
  // Channel start
  input wire logic [31:0] CHAN_START_DONE_IN,
  output logic [31:0] CHAN_START_OUT,
  // Transmit reference
  input wire logic REF_OSC_IN,
  input wire logic REF_PLL_A_IN,
  output logic TX_HIGH_TICK_OUT,
  output logic TX_LOW_TICK_OUT,
  // Transceiver lines
  input wire logic [33:0] LINE_IN,
  input wire logic [33:0] SM_DATA_IN,
  input wire logic [33:0] SM_OE_IN,
  output logic [33:0] LINE_DATA_OUT,
  output logic [33:0] LINE_OE_OUT,
  output logic [33:0] LINE_TERM_OUT,
  // Switches and PLL
  input wire logic [7:0] DIP_SW_IN,
  input wire logic PLL_DATA_IN,
  output logic PLL_DATA_OUT,
  output logic PLL_DATA_OE_OUT,
  output logic PLL_SCLK_OUT,
  output logic PLL_ENABLE_OUT
);

  // ==========================================================
  // Functions
  // Line ownership: state machine when mux set, else parallel port
  function automatic logic pick(input logic mux, input logic sm, input logic par);
    pick = mux ? sm : par;
  endfunction

  // ==========================================================
  // Declarations
  logic [`SIH_BASE_WIDTH-1:0] base_q, base_d;
  sih_pkg::sih_word_t start_q, start_d;
  sih_pkg::sih_word_t data_q, data_d;
  sih_pkg::sih_word_t dir_q, dir_d;
  sih_pkg::sih_word_t term_q, term_d;
  sih_pkg::sih_word_t mux_q, mux_d;
  logic [1:0] up_data_q, up_data_d;
  logic [1:0] up_dir_q, up_dir_d;
  logic [1:0] up_term_q, up_term_d;
  logic [1:0] up_mux_q, up_mux_d;
  logic [3:0] pll_q, pll_d;
  sih_pkg::sih_word_t msg_addr_q, msg_addr_d;
  sih_pkg::sih_word_t rdata_d;
  logic wr_base, wr_set, wr_clr;
  logic [44:0] pins_s;
  sih_pkg::sih_lines_t line_s;
  logic [7:0] sw_s;
  logic pdat_s, osc_s, pll_s;

  // Synchronised pin levels, one instance for all pins
  sih_sync #(.W(45)) u_sync (
    .clk_in(CLOCK_IN),
    .rst_in(RESET_IN),
    .async_in({REF_PLL_A_IN, REF_OSC_IN, PLL_DATA_IN, DIP_SW_IN, LINE_IN}),
    .sync_out(pins_s)
  );

  always_comb begin
    line_s = pins_s[33:0];
    sw_s = pins_s[41:34];
    pdat_s = pins_s[42];
    osc_s = pins_s[43];
    pll_s = pins_s[44];
  end

  // ==========================================================
  // Register writes
  always_comb begin
    wr_base = REG_WR_IN && (REG_ADDR_IN == `SIH_OFF_BASE_CONTROL);
    wr_set = REG_WR_IN && (REG_ADDR_IN == `SIH_OFF_CHANNEL_START_SET);
    wr_clr = REG_WR_IN && (REG_ADDR_IN == `SIH_OFF_CHANNEL_START_CLEAR);
    base_d = base_q;
    data_d = data_q;
    dir_d = dir_q;
    term_d = term_q;
    mux_d = mux_q;
    up_data_d = up_data_q;
    up_dir_d = up_dir_q;
    up_term_d = up_term_q;
    up_mux_d = up_mux_q;
    pll_d = pll_q;
    msg_addr_d = msg_addr_q;
    if (wr_base) begin
      base_d = REG_WDATA_IN[`SIH_BASE_WIDTH-1:0];
    end
    if (REG_WR_IN) begin
      unique case (REG_ADDR_IN)
        `SIH_OFF_PARALLEL_OUTPUT_DATA: data_d = REG_WDATA_IN;
        `SIH_OFF_LINE_DIRECTION: dir_d = REG_WDATA_IN;
        `SIH_OFF_LINE_TERMINATION: term_d = REG_WDATA_IN;
        `SIH_OFF_LINE_SOURCE_SELECT: mux_d = REG_WDATA_IN;
        `SIH_OFF_UPPER_LINE_CONTROL: begin
          up_data_d = REG_WDATA_IN[`SIH_UPPER_DATA_LSB +: 2]; // RL17
          up_dir_d = REG_WDATA_IN[`SIH_UPPER_DIR_LSB +: 2];
          up_term_d = REG_WDATA_IN[`SIH_UPPER_TERM_LSB +: 2];
          up_mux_d = REG_WDATA_IN[`SIH_UPPER_MUX_LSB +: 2];
        end
        `SIH_OFF_PLL_COMMAND: pll_d = REG_WDATA_IN[3:0];
        `SIH_OFF_MESSAGE_TARGET_ADDRESS: msg_addr_d = REG_WDATA_IN;
        default: ;
      endcase
    end
  end

  // Start bits: only ones act; software set beats a same-cycle hardware clear
  always_comb begin
    start_d = start_q & ~CHAN_START_DONE_IN; // RL9
    if (wr_clr) begin
      start_d = start_d & ~REG_WDATA_IN; // RL10 RL23
    end
    if (wr_set) begin
      start_d = start_d | REG_WDATA_IN; // RL8 RL23
    end
  end

  // Control registers, all cleared by reset
  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      base_q <= '0; // RL6
      start_q <= `SIH_RESET_WORD;
      data_q <= `SIH_RESET_WORD;
      dir_q <= `SIH_RESET_WORD;
      term_q <= `SIH_RESET_WORD;
      mux_q <= `SIH_RESET_WORD;
      up_data_q <= '0;
      up_dir_q <= '0;
      up_term_q <= '0;
      up_mux_q <= '0;
      pll_q <= '0;
      msg_addr_q <= `SIH_RESET_WORD;
    end else begin
      base_q <= base_d;
      start_q <= start_d;
      data_q <= data_d;
      dir_q <= dir_d;
      term_q <= term_d;
      mux_q <= mux_d;
      up_data_q <= up_data_d;
      up_dir_q <= up_dir_d;
      up_term_q <= up_term_d;
      up_mux_q <= up_mux_d;
      pll_q <= pll_d;
      msg_addr_q <= msg_addr_d;
    end
  end

  // ==========================================================
  // Register reads, no side effects; unmapped reads return zero
  always_comb begin
    rdata_d = `SIH_RESET_WORD;
    unique case (REG_ADDR_IN)
      `SIH_OFF_BASE_CONTROL: rdata_d[`SIH_BASE_WIDTH-1:0] = base_q;
      `SIH_OFF_DESIGN_REVISION_ID: rdata_d = {DESIGN_ID, FW_REVISION}; // RL7
      `SIH_OFF_CHANNEL_START_SET: rdata_d = start_q; // RL8
      `SIH_OFF_PARALLEL_OUTPUT_DATA: rdata_d = data_q; // RL13
      `SIH_OFF_LINE_DIRECTION: rdata_d = dir_q;
      `SIH_OFF_LINE_TERMINATION: rdata_d = term_q;
      `SIH_OFF_LINE_SOURCE_SELECT: rdata_d = mux_q;
      `SIH_OFF_UPPER_LINE_CONTROL: begin
        rdata_d[`SIH_UPPER_DATA_LSB +: 2] = up_data_q; // RL17
        rdata_d[`SIH_UPPER_DIR_LSB +: 2] = up_dir_q;
        rdata_d[`SIH_UPPER_TERM_LSB +: 2] = up_term_q;
        rdata_d[`SIH_UPPER_MUX_LSB +: 2] = up_mux_q;
      end
      `SIH_OFF_SWITCH_STATUS: rdata_d[`SIH_SWITCH_LSB +: 8] = sw_s; // RL21
      // Data bit shows the wire, which the PLL may hold low
      `SIH_OFF_PLL_COMMAND: rdata_d[3:0] = {pll_q[3:1], pdat_s};
      `SIH_OFF_PLL_COMMAND_READBACK: rdata_d[3:0] = pll_q;
      `SIH_OFF_LINE_READBACK: rdata_d = line_s[31:0]; // RL19
      `SIH_OFF_UPPER_LINE_READBACK: rdata_d[1:0] = line_s[33:32]; // RL20
      `SIH_OFF_MESSAGE_TARGET_ADDRESS: rdata_d = msg_addr_q;
      default: ;
    endcase
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      REG_RDATA_OUT <= `SIH_RESET_WORD;
      REG_RVALID_OUT <= 1'b0;
    end else begin
      REG_RDATA_OUT <= REG_RD_IN ? rdata_d : `SIH_RESET_WORD;
      REG_RVALID_OUT <= REG_RD_IN;
    end
  end

  // ==========================================================
  // Interrupt and message-interrupt logic
  logic irq_src, irq_prev_q, irq_rise;
  logic collect_q, collect_d;
  logic msg_req_d;
  sih_pkg::sih_msg_e msg_q, msg_d;

  always_comb begin
    irq_src = (|CHAN_IRQ_IN) | (base_q[`SIH_BASE_IRQ_SET] & base_q[`SIH_BASE_IRQ_MASTER]);
    irq_rise = irq_src & ~irq_prev_q;
    msg_d = msg_q;
    collect_d = collect_q;
    // Clear on a write of the clear bit; a new event in that cycle still lands
    if (wr_base && REG_WDATA_IN[`SIH_BASE_MSG_CLEAR]) begin
      collect_d = 1'b0; // RL4
    end
    unique case (msg_q)
      sih_pkg::SIH_MSG_IDLE: begin
        if (base_q[`SIH_BASE_MSG_ENABLE] && collect_q) begin
          msg_d = sih_pkg::SIH_MSG_WAIT; // RL3
          collect_d = 1'b0;
        end
      end
      sih_pkg::SIH_MSG_WAIT: begin
        if (MSG_WR_ACK_IN) begin
          msg_d = sih_pkg::SIH_MSG_IDLE;
        end
      end
    endcase
    if (irq_rise) begin
      collect_d = 1'b1;
    end
    msg_req_d = (msg_d == sih_pkg::SIH_MSG_WAIT);
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      irq_prev_q <= 1'b0;
      collect_q <= 1'b0;
      msg_q <= sih_pkg::SIH_MSG_IDLE;
      MSG_WR_REQ_OUT <= 1'b0;
      MSG_WR_ADDR_OUT <= `SIH_RESET_WORD;
      CARRIER_IRQ_OUT <= 1'b0;
    end else begin
      irq_prev_q <= irq_src;
      collect_q <= collect_d;
      msg_q <= msg_d;
      MSG_WR_REQ_OUT <= msg_req_d;
      MSG_WR_ADDR_OUT <= msg_addr_q; // RL3
      CARRIER_IRQ_OUT <= base_q[`SIH_BASE_IRQ_MASTER] & irq_src; // RL1 RL2
    end
  end

  // ==========================================================
  // Transmit reference dividers
  // Pin clocks pass the agreement gate, so each reference must stay well under 62.5 MHz
  logic ref_s, ref_prev_q, ref_rise;
  logic [6:0] hi_cnt_q, hi_cnt_d, lo_cnt_q, lo_cnt_d;
  logic hi_tick_d, lo_tick_d;

  always_comb begin
    ref_s = base_q[`SIH_BASE_REF_SELECT] ? pll_s : osc_s; // RL5
    ref_rise = ref_s & ~ref_prev_q;
    hi_cnt_d = hi_cnt_q;
    lo_cnt_d = lo_cnt_q;
    hi_tick_d = 1'b0;
    lo_tick_d = 1'b0;
    if (ref_rise) begin
      hi_tick_d = (hi_cnt_q == `SIH_DIV_HIGH - 7'h01); // RL5
      lo_tick_d = (lo_cnt_q == `SIH_DIV_LOW - 7'h01);
      hi_cnt_d = hi_tick_d ? 7'h00 : hi_cnt_q + 7'h01;
      lo_cnt_d = lo_tick_d ? 7'h00 : lo_cnt_q + 7'h01;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      ref_prev_q <= 1'b0;
      hi_cnt_q <= '0;
      lo_cnt_q <= '0;
      TX_HIGH_TICK_OUT <= 1'b0;
      TX_LOW_TICK_OUT <= 1'b0;
    end else begin
      ref_prev_q <= ref_s;
      hi_cnt_q <= hi_cnt_d;
      lo_cnt_q <= lo_cnt_d;
      TX_HIGH_TICK_OUT <= hi_tick_d;
      TX_LOW_TICK_OUT <= lo_tick_d;
    end
  end

  // ==========================================================
  // Line drivers, start bits and PLL pins
  sih_pkg::sih_lines_t ld_d, oe_d;

  always_comb begin
    for (int i = 0; i < 32; i++) begin
      ld_d[i] = pick(mux_q[i], SM_DATA_IN[i], data_q[i]); // RL12 RL16
      oe_d[i] = pick(mux_q[i], SM_OE_IN[i], dir_q[i]); // RL14
    end
    for (int j = 0; j < 2; j++) begin
      // Upper lines have no channel data; mux forces the data low
      ld_d[32+j] = pick(up_mux_q[j], 1'b0, up_data_q[j]); // RL18
      oe_d[32+j] = pick(up_mux_q[j], SM_OE_IN[32+j], up_dir_q[j]);
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      LINE_DATA_OUT <= '0;
      LINE_OE_OUT <= '0;
      LINE_TERM_OUT <= '0;
      CHAN_START_OUT <= `SIH_RESET_WORD;
      PLL_DATA_OUT <= 1'b0;
      PLL_DATA_OE_OUT <= 1'b0;
      PLL_SCLK_OUT <= 1'b0;
      PLL_ENABLE_OUT <= 1'b0;
    end else begin
      LINE_DATA_OUT <= ld_d;
      LINE_OE_OUT <= oe_d;
      LINE_TERM_OUT <= {up_term_q, term_q}; // RL15
      CHAN_START_OUT <= start_q; // RL11
      PLL_DATA_OUT <= 1'b0;
      PLL_DATA_OE_OUT <= pll_q[`SIH_PLL_ENABLE] & ~pll_q[`SIH_PLL_DATA]; // RL22
      PLL_SCLK_OUT <= pll_q[`SIH_PLL_SCLK];
      PLL_ENABLE_OUT <= pll_q[`SIH_PLL_ENABLE];
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (RESET_IN);

  a_irq_passes: assert property ( // RL1
    base_q[0] && (|CHAN_IRQ_IN) |=> CARRIER_IRQ_OUT)
    else $error("irq not passed to carrier");
  a_irq_blocked: assert property ( // RL1
    !base_q[0] |=> !CARRIER_IRQ_OUT)
    else $error("irq driven while master off");
  a_irq_forced: assert property ( // RL2
    base_q[0] && base_q[1] |=> CARRIER_IRQ_OUT)
    else $error("forced irq missing");
  a_msg_disabled: assert property ( // RL3
    !base_q[2] && msg_q == sih_pkg::SIH_MSG_IDLE |=> !MSG_WR_REQ_OUT)
    else $error("message write while disabled");
  a_msg_cleared: assert property ( // RL4
    wr_base && REG_WDATA_IN[3] && !irq_rise |=> !collect_q)
    else $error("collection not cleared");
  a_reset_zero: assert property (@(posedge CLOCK_IN) disable iff (1'b0) // RL6
    RESET_IN |=> base_q == '0 && start_q == '0)
    else $error("control not zero after reset");
  a_id_read: assert property ( // RL7
    REG_RD_IN && REG_ADDR_IN == 8'h04 |=> REG_RDATA_OUT == {DESIGN_ID, FW_REVISION})
    else $error("bad identifier read");
  a_start_set: assert property ( // RL8
    wr_set |-> ##2 (CHAN_START_OUT & $past(REG_WDATA_IN, 2)) == $past(REG_WDATA_IN, 2))
    else $error("start set lost");
  a_start_done: assert property ( // RL9
    CHAN_START_DONE_IN[31] && !wr_set |=> !start_q[31])
    else $error("machine clear ignored");
  a_start_clear: assert property ( // RL10 RL11
    wr_clr && REG_WDATA_IN[0] |=> ##1 !CHAN_START_OUT[0])
    else $error("start clear lost");
  a_start_hold: assert property ( // RL23
    !wr_set && !wr_clr && CHAN_START_DONE_IN == '0 |=> $stable(start_q))
    else $error("start changed without cause");
  a_line_drive: assert property ( // RL12 RL14
    !mux_q[0] |=> LINE_OE_OUT[0] == $past(dir_q[0]) && LINE_DATA_OUT[0] == $past(data_q[0]))
    else $error("parallel drive wrong");
  a_term_follow: assert property ( // RL15
    1'b1 |=> LINE_TERM_OUT == $past({up_term_q, term_q}))
    else $error("termination wrong");
  a_upper_zero: assert property ( // RL18
    up_mux_q[0] |=> !LINE_DATA_OUT[32])
    else $error("upper data not forced low");
  a_pll_tristate: assert property ( // RL22
    !pll_q[3] |=> !PLL_DATA_OE_OUT)
    else $error("pll data driven while disabled");

  c_start: cover property (wr_set ##2 CHAN_START_OUT != '0);
  c_msg: cover property (MSG_WR_REQ_OUT ##[1:20] MSG_WR_ACK_IN);
  c_irq: cover property (CARRIER_IRQ_OUT);
  c_tick: cover property (TX_LOW_TICK_OUT);

endmodule // sih_top

`default_nettype wire

//--- bench/sih_host.sv
// Purpose: Host model on the far side of the local register port
// Assumes: Strobes change at the falling edge, one word per access
// Notes:   Acknowledges message writes after ack_wait cycles
`timescale 1ns/10ps
`default_nettype none

module sih_host (
  // Clock
  input wire logic clk_in,
  // Register port
  output logic [7:0] addr_out,
  output logic wr_out,
  output logic rd_out,
  output logic [31:0] wdata_out,
  input wire logic [31:0] rdata_in,
  input wire logic rvalid_in,
  // Message write
  input wire logic msg_req_in,
  output logic msg_ack_out
);
  int ack_wait = 3;
  int cnt = 0;
  int n_ack = 0;

  // ==========================================================
  // Idle bus; unused data carries a changing pattern
  initial begin
    addr_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
    wdata_out = 32'h0000_0000;
    msg_ack_out = 1'b0;
  end

  // ==========================================================
  // One write, taken at the rising edge in between
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk_in);
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(negedge clk_in);
    wr_out = 1'b0;
    wdata_out = ~d;
  endtask

  // One read; answer stands for exactly one cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output bit ok);
    @(negedge clk_in);
    addr_out = a;
    rd_out = 1'b1;
    @(negedge clk_in);
    rd_out = 1'b0;
    ok = (rvalid_in === 1'b1);
    d = rdata_in;
  endtask

  // ==========================================================
  // Slow acknowledge; the wait stops a double accept
  always @(negedge clk_in) begin
    if (msg_ack_out) begin
      msg_ack_out <= 1'b0;
      cnt <= 0;
    end else if (msg_req_in === 1'b1) begin
      if (cnt >= ack_wait) begin
        msg_ack_out <= 1'b1;
        n_ack <= n_ack + 1;
      end
      cnt <= cnt + 1;
    end
  end
endmodule // sih_host

`default_nettype wire

//--- bench/tb_top.sv
// Purpose: Self-checking bench of the host register bank
// Assumes: Inputs change at the falling edge, 250 MHz clock
// Notes:   Lines and PLL data wire resolved from all drivers
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  localparam logic [15:0] ID_V = 16'h3C3C; // Arbitrary value
  localparam logic [15:0] REV_V = 16'h0042; // Arbitrary value
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [31:0] chan_irq = 32'h0000_0000;
  logic [31:0] done = 32'h0000_0000;
  logic osc = 1'b0;
  logic pll = 1'b0;
  logic [33:0] ext = 34'h2_C3A5_965A;
  logic [33:0] sm_data = 34'h1_3C3C_C3C3;
  logic [33:0] sm_oe = 34'h0_F00F_F00F;
  logic [7:0] dip = 8'h12;
  logic [7:0] addr;
  logic wr_s, rd_s, rvalid, irq, req, ack, tx_hi, tx_lo;
  logic pdat, pdat_oe, sclk, pll_en, wire_lvl;
  logic [31:0] wdata, rdata, msg_addr, chan_start;
  logic [33:0] line_in, line_data, line_oe, line_term;
  int n_fail = 0;
  int checked = 0;

  // ==========================================================
  // Clocks; references toggle on falling edges only
  always #2 clock = ~clock;
  always #20 osc = ~osc;
  always #12 pll = ~pll;
  // Driven lines show their own data; PLL wire has a pull-up
  assign line_in = (line_oe & line_data) | (~line_oe & ext);
  assign wire_lvl = ~(pdat_oe & ~pdat);

  sih_top #(.DESIGN_ID(ID_V), .FW_REVISION(REV_V)) i_sih_top (
    .CLOCK_IN(clock), .RESET_IN(reset), .REG_ADDR_IN(addr), .REG_WR_IN(wr_s),
    .REG_RD_IN(rd_s), .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata),
    .REG_RVALID_OUT(rvalid), .CHAN_IRQ_IN(chan_irq), .CARRIER_IRQ_OUT(irq),
    .MSG_WR_REQ_OUT(req), .MSG_WR_ADDR_OUT(msg_addr), .MSG_WR_ACK_IN(ack),
    .CHAN_START_DONE_IN(done), .CHAN_START_OUT(chan_start), .REF_OSC_IN(osc),
    .REF_PLL_A_IN(pll), .TX_HIGH_TICK_OUT(tx_hi), .TX_LOW_TICK_OUT(tx_lo),
    .LINE_IN(line_in), .SM_DATA_IN(sm_data), .SM_OE_IN(sm_oe),
    .LINE_DATA_OUT(line_data), .LINE_OE_OUT(line_oe), .LINE_TERM_OUT(line_term),
    .DIP_SW_IN(dip), .PLL_DATA_IN(wire_lvl), .PLL_DATA_OUT(pdat),
    .PLL_DATA_OE_OUT(pdat_oe), .PLL_SCLK_OUT(sclk), .PLL_ENABLE_OUT(pll_en));

  sih_host i_sih_host (
    .clk_in(clock), .addr_out(addr), .wr_out(wr_s), .rd_out(rd_s),
    .wdata_out(wdata), .rdata_in(rdata), .rvalid_in(rvalid),
    .msg_req_in(req), .msg_ack_out(ack));

  // ==========================================================
  // Helpers
  task automatic report_and_stop;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_sih_host.wr(a, d);
  endtask

  // Read with optional mask over bits not defined
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
                       input logic [31:0] m = 32'hFFFF_FFFF);
    logic [31:0] d;
    bit ok;
    i_sih_host.rd(a, d, ok);
    chk({31'h0, ok}, 32'h0000_0001);
    chk(d & m, e & m);
  endtask

  // Bounded wait on the message request level
  task automatic wait_req(input logic lvl);
    int k;
    k = 0;
    while (req !== lvl && k < 30) begin
      cyc(1);
      k++;
    end
    if (k == 30) begin
      n_fail++;
      report_and_stop;
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    reset = 1'b1;
    cyc(3);
    reset = 1'b0;
    rdchk(8'h00, 32'h0000_0000);
    rdchk(8'h08, 32'h0000_0000);
    rdchk(8'h10, 32'h0000_0000);
    chk({pdat_oe, line_oe[31:0]} == 33'h0, 32'h0000_0001);
  endtask

  task automatic t_id;
    rdchk(8'h04, {ID_V, REV_V});
    wr(8'h04, 32'hFFFF_FFFF);
    rdchk(8'h04, {ID_V, REV_V});
    rdchk(8'h30, 32'h0000_0000);
    rdchk(8'h24, 32'h0012_0000);
    rdchk(8'hC0, ext[31:0]);
    rdchk(8'hC4, {30'h0, ext[33:32]});
  endtask

  task automatic t_start;
    wr(8'h08, 32'h8000_0001);
    rdchk(8'h08, 32'h8000_0001);
    chk(chan_start, 32'h8000_0001);
    wr(8'h08, 32'h0000_0000);
    wr(8'h0C, 32'h0000_0000);
    rdchk(8'h08, 32'h8000_0001);
    wr(8'h0C, 32'h0000_0001);
    rdchk(8'h08, 32'h8000_0000);
    done = 32'h8000_0000;
    cyc(1);
    done = 32'h0000_0000;
    cyc(2);
    chk(chan_start, 32'h0000_0000);
  endtask

  task automatic t_irq(input logic [31:0] base, input logic [31:0] src, input logic e);
    wr(8'h00, base);
    chan_irq = src;
    cyc(3);
    chk({31'h0, irq}, {31'h0, e});
  endtask

  task automatic t_msg;
    int a0;
    wr(8'hD4, 32'h0000_ABC0);
    chan_irq = 32'h0000_0001;
    cyc(2);
    chan_irq = 32'h0000_0000;
    wr(8'h00, 32'h0000_0008);
    wr(8'h00, 32'h0000_0004);
    cyc(8);
    chk({31'h0, req}, 32'h0000_0000);
    a0 = i_sih_host.n_ack;
    chan_irq = 32'h0000_0002;
    wait_req(1'b1);
    chk(msg_addr, 32'h0000_ABC0);
    wait_req(1'b0);
    chk(i_sih_host.n_ack - a0, 32'h0000_0001);
    chan_irq = 32'h0000_0000;
    wr(8'h00, 32'h0000_0000);
  endtask

  task automatic t_lines;
    logic [31:0] par;
    par = 32'hFFFF_0000 & ~32'h00FF_FF00;
    wr(8'h10, 32'hA5A5_5A5A);
    wr(8'h14, 32'hFFFF_0000);
    wr(8'h18, 32'h0F0F_F0F0);
    wr(8'h1C, 32'h00FF_FF00);
    wr(8'h20, 32'h0102_0303);
    cyc(3);
    chk(line_oe[31:0], par | (32'h00FF_FF00 & sm_oe[31:0]));
    chk(line_data[31:0] & par, 32'hA5A5_5A5A & par);
    chk(line_data[31:0] & 32'h00FF_FF00, sm_data[31:0] & 32'h00FF_FF00);
    chk(line_term[31:0], 32'h0F0F_F0F0);
    chk({26'h0, line_data[33:32], line_oe[33:32], line_term[33:32]}, 32'h2A);
    rdchk(8'h10, 32'hA5A5_5A5A);
    rdchk(8'h20, 32'h0102_0303);
    cyc(6);
    rdchk(8'hC0, 32'hA5A5_5A5A, par);
  endtask

  // Pins {en,sclk,oe,data}; readback {en,spare,sclk,wire}
  task automatic t_pll(input logic [31:0] w, input logic [31:0] pins, input logic [31:0] rb);
    wr(8'h28, w);
    cyc(8);
    chk({28'h0, pll_en, sclk, pdat_oe, pdat}, pins);
    rdchk(8'h28, rb);
    rdchk(8'h2C, w);
  endtask

  // Count ticks over 1600 cycles against reference edges
  task automatic t_ref(input logic [31:0] base, input int edges);
    int hi;
    int lo;
    hi = 0;
    lo = 0;
    wr(8'h00, base);
    cyc(20);
    repeat (1600) begin
      cyc(1);
      hi += tx_hi;
      lo += tx_lo;
    end
    chk(hi >= edges / 8 - 1 && hi <= edges / 8 + 1, 32'h0000_0001);
    chk(lo >= edges / 100 && lo <= edges / 100 + 1, 32'h0000_0001);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    t_reset();
    t_id();
    t_start();
    t_irq(32'h0000_0003, 32'h0000_0000, 1'b1);
    t_irq(32'h0000_0002, 32'h0000_0000, 1'b0);
    t_irq(32'h0000_0001, 32'h0000_0020, 1'b1);
    t_irq(32'h0000_0000, 32'h0000_0020, 1'b0);
    t_msg();
    t_lines();
    t_pll(32'h0000_000A, 32'h0000_000E, 32'h0000_000A);
    t_pll(32'h0000_0002, 32'h0000_0004, 32'h0000_0003);
    t_pll(32'h0000_0009, 32'h0000_0008, 32'h0000_0009);
    t_ref(32'h0000_0000, 160);
    t_ref(32'h0000_0010, 266);
    t_reset();
    report_and_stop();
  end
endmodule // tb_top

`default_nettype wire
